// ==== core/imc_pkg.sv ====
package imc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS       = 25;
    localparam int LINK_NS      = 15;
    localparam int TBUF_STD_NS  = 4700;
    localparam int TBUF_FAST_NS = 1300;
    localparam int SCL_HALF_NS  = 10500;
    localparam logic [7:0] TBUF_STD_CYC =
        8'((TBUF_STD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] TBUF_FAST_CYC =
        8'((TBUF_FAST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] SCL_HALF_CYC = 10'(SCL_HALF_NS / LINK_NS);

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 16;
    localparam logic [3:0] BITS_LAST = 4'h7;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
    } imc_pins_type;

    typedef enum logic [1:0] {OP_START, OP_BYTE, OP_STOP} imc_op_type;

    typedef enum logic [2:0] {
        S_IDLE, S_WAIT, S_GAP, S_START, S_HOLD, S_BYTE, S_STOP
    } imc_sys_state_type;

    typedef enum logic [3:0] {
        L_IDLE, L_START, L_HOLD, L_RS, L_BITLO, L_BITHI,
        L_ACKLO, L_ACKHI, L_STOP
    } imc_link_state_type;

    typedef struct packed {
        imc_op_type op;
        logic [7:0] data;
        logic       tgl;
    } imc_req_type;

    typedef struct packed {
        logic stt;
        logic stp;
        logic fall;
        logic done;
    } imc_evt_type;
endpackage

// ==== core/imc_start_ctrl.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Transmit FIFO
// ----------------------------------------------------------------
module imc_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         flush,
    input  wire logic [W-1:0] inData,
    input  wire logic         inValid,
    output logic              inReady,
    output logic [W-1:0]      outData,
    output logic              outValid,
    input  wire logic         outReady
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
        logic                rdy;
    } imc_fifo_state_type;
    imc_fifo_state_type r;
    imc_fifo_state_type n;
    logic wr;
    logic rd;

    always_comb begin
        n = r;
        wr = inValid && r.rdy;
        rd = outReady && (r.cnt != '0);
        if (wr) begin
            n.mem[r.wp] = inData;
            n.wp = r.wp + 1'b1;
        end
        if (rd) begin
            n.rp = r.rp + 1'b1;
        end
        n.cnt = r.cnt + (AW+1)'(wr) - (AW+1)'(rd);
        if (flush) begin
            n.wp = '0;
            n.rp = '0;
            n.cnt = '0;
        end
        n.rdy = (n.cnt != (AW+1)'(D));
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign inReady  = r.rdy;
    assign outValid = (r.cnt != '0);
    assign outData  = r.mem[r.rp];
endmodule // imc_fifo

// ----------------------------------------------------------------
// Link side: bus monitor and condition generator
// ----------------------------------------------------------------
module imc_link (
    input  wire logic           linkClk,
    input  wire logic           reset_n,
    input  imc_pkg::imc_pins_type pinsIn,
    input  imc_pkg::imc_req_type  req,
    output imc_pkg::imc_pins_type pinsOut,
    output imc_pkg::imc_pins_type pinsOe,
    output logic                busy,
    output logic                nack,
    output imc_pkg::imc_evt_type  evt
);
    import imc_pkg::*;
    typedef struct packed {
        imc_pins_type       s1;
        imc_pins_type       s2;
        imc_pins_type       s3;
        logic               rq1;
        logic               rq2;
        logic               seen;
        logic               busy;
        logic               nack;
        imc_evt_type        evt;
        imc_link_state_type st;
        logic [9:0]         cnt;
        logic [3:0]         bitN;
        logic [7:0]         sh;
        imc_pins_type       oe;
        imc_pins_type       lvl;
    } imc_link_state_rec_type;
    imc_link_state_rec_type r;
    imc_link_state_rec_type n;
    logic sttDet;
    logic stpDet;
    logic newReq;
    logic cntDone;

    always_comb begin
        n = r;
        n.s1 = pinsIn;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.rq1 = req.tgl;
        n.rq2 = r.rq1;
        sttDet = r.s3.sda & ~r.s2.sda & r.s3.scl & r.s2.scl;
        stpDet = ~r.s3.sda & r.s2.sda & r.s3.scl & r.s2.scl;
        newReq = (r.rq2 != r.seen);
        cntDone = (r.cnt == '0);
        if (!cntDone) begin
            n.cnt = r.cnt - 1'b1;
        end
        if (sttDet) begin
            n.busy = 1'b1;
            n.evt.stt = ~r.evt.stt;
        end
        if (stpDet) begin
            n.busy = 1'b0;
            n.evt.stp = ~r.evt.stp;
        end
        if (r.s3.scl & ~r.s2.scl) begin
            n.evt.fall = ~r.evt.fall;
        end
        case (r.st)
            L_IDLE: if (newReq) begin
                n.seen = r.rq2;
                if (req.op == OP_START) begin
                    n.oe.sda = 1'b1;
                    n.cnt = SCL_HALF_CYC;
                    n.st = L_START;
                end else begin
                    n.evt.done = ~r.evt.done;
                end
            end
            L_START: if (cntDone) begin
                n.oe.scl = 1'b1;
                n.cnt = SCL_HALF_CYC;
                n.st = L_HOLD;
                n.evt.done = ~r.evt.done;
            end
            L_HOLD: if (newReq && cntDone) begin
                n.seen = r.rq2;
                n.cnt = SCL_HALF_CYC;
                case (req.op)
                    OP_START: begin
                        n.oe.sda = 1'b0;
                        n.st = L_RS;
                    end
                    OP_BYTE: begin
                        n.sh = req.data;
                        n.bitN = '0;
                        n.oe.sda = ~req.data[7];
                        n.st = L_BITLO;
                    end
                    default: begin
                        n.oe.sda = 1'b1;
                        n.st = L_STOP;
                    end
                endcase
            end
            L_RS: if (cntDone) begin
                n.cnt = SCL_HALF_CYC;
                if (r.oe.scl) begin
                    n.oe.scl = 1'b0;
                end else begin
                    n.oe.sda = 1'b1;
                    n.st = L_START;
                end
            end
            L_BITLO: if (cntDone) begin
                n.oe.scl = 1'b0;
                n.cnt = SCL_HALF_CYC;
                n.st = L_BITHI;
            end
            L_BITHI: if (cntDone) begin
                n.oe.scl = 1'b1;
                n.cnt = SCL_HALF_CYC;
                if (r.bitN == BITS_LAST) begin
                    n.oe.sda = 1'b0;
                    n.st = L_ACKLO;
                end else begin
                    n.bitN = r.bitN + 1'b1;
                    n.sh = {r.sh[6:0], 1'b0};
                    n.oe.sda = ~r.sh[6];
                    n.st = L_BITLO;
                end
            end
            L_ACKLO: if (cntDone) begin
                n.oe.scl = 1'b0;
                n.cnt = SCL_HALF_CYC;
                n.st = L_ACKHI;
            end
            L_ACKHI: if (cntDone) begin
                n.nack = r.s2.sda;
                n.oe.scl = 1'b1;
                n.cnt = SCL_HALF_CYC;
                n.st = L_HOLD;
                n.evt.done = ~r.evt.done;
            end
            L_STOP: if (cntDone) begin
                n.cnt = SCL_HALF_CYC;
                if (r.oe.scl) begin
                    n.oe.scl = 1'b0;
                end else begin
                    n.oe.sda = 1'b0;
                    n.st = L_IDLE;
                    n.evt.done = ~r.evt.done;
                end
            end
            default: n.st = L_IDLE;
        endcase
    end

    always_ff @(posedge linkClk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign pinsOut = r.lvl;
    assign pinsOe  = r.oe;
    assign busy    = r.busy;
    assign nack    = r.nack;
    assign evt     = r.evt;

    chk_busy_track: assert property (
        @(posedge linkClk) disable iff (!reset_n)
        (sttDet || (r.busy && !stpDet)) |=> r.busy)
        else $error("busy not held from start to stop");
endmodule // imc_link

// ----------------------------------------------------------------
// System side: start control, flags, transmit path
// ----------------------------------------------------------------
module imc_start_ctrl (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             linkClk,
    input  wire logic             startReq,
    input  wire logic             stopReq,
    input  wire logic             multiMasterEnable,
    input  wire logic             transmitterSelect,
    input  wire logic             fastMode,
    input  wire logic             globalIrqEnable,
    input  wire logic             clrStartSeen,
    input  wire logic             clrStopSeen,
    input  wire logic             clrNoAck,
    input  wire logic [7:0]       txData,
    input  wire logic             txValid,
    output logic                  txReady,
    input  imc_pkg::imc_pins_type pinsIn,
    output imc_pkg::imc_pins_type pinsOut,
    output imc_pkg::imc_pins_type pinsOe,
    output logic                  startRequest,
    output logic                  busBusy,
    output logic                  startSeen,
    output logic                  stopSeen,
    output logic                  noAck,
    output logic                  txReadyFlag
);
    import imc_pkg::*;
    typedef struct packed {
        logic              b1;
        logic              b2;
        imc_evt_type       e1;
        imc_evt_type       e2;
        imc_evt_type       e3;
        logic              startRequest;
        logic              stopPending;
        imc_req_type       req;
        imc_sys_state_type st;
        logic [7:0]        cnt;
        logic              startSeen;
        logic              stopSeen;
        logic              noAck;
        logic              txRdy;
        logic [1:0]        gieD;
    } imc_sys_rec_type;
    imc_sys_rec_type r;
    imc_sys_rec_type n;
    logic        busyL;
    logic        nackL;
    imc_evt_type evtL;
    imc_evt_type ev;
    logic        mmTx;
    logic        gieWin;
    logic        flush;
    logic        pop;
    logic        fInReady;
    logic [7:0]  fData;
    logic        fValid;
    logic [7:0]  tbuf;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.b1 = busyL;
        n.b2 = r.b1;
        n.e1 = evtL;
        n.e2 = r.e1;
        n.e3 = r.e2;
        n.gieD = {r.gieD[0], globalIrqEnable};
        ev = r.e2 ^ r.e3;
        mmTx = multiMasterEnable & transmitterSelect;
        gieWin = globalIrqEnable & ~r.gieD[1];
        tbuf = fastMode ? TBUF_FAST_CYC : TBUF_STD_CYC;
        flush = (r.st == S_WAIT) & mmTx;
        pop = 1'b0;
        n.startSeen = (r.startSeen & ~clrStartSeen
                       & ~(ev.stp & ~gieWin)) | ev.stt;
        n.stopSeen = (r.stopSeen & ~clrStopSeen
                      & ~(ev.stt & ~gieWin)) | ev.stp;
        n.noAck = (r.noAck & ~clrNoAck & ~(ev.stt & ~gieWin))
                  | ((r.st == S_BYTE) & ev.done & nackL);
        if (flush) begin
            n.txRdy = ev.fall | (r.txRdy & ~txValid);
        end else begin
            n.txRdy = fInReady;
        end
        case (r.st)
            S_IDLE: if (r.startRequest) begin
                if (r.b2) begin
                    n.st = S_WAIT;
                end else begin
                    n.cnt = tbuf;
                    n.st = S_GAP;
                end
            end else begin
                n.stopPending = 1'b0;
            end
            S_WAIT: if (!r.b2) begin
                n.cnt = tbuf;
                n.st = S_GAP;
            end
            S_GAP: if (r.b2) begin
                n.st = S_WAIT;
            end else if (r.cnt == '0) begin
                n.req.op = OP_START;
                n.req.tgl = ~r.req.tgl;
                n.st = S_START;
            end else begin
                n.cnt = r.cnt - 1'b1;
            end
            S_START: if (ev.done) begin
                n.startRequest = 1'b0;
                n.st = S_HOLD;
            end
            S_HOLD: if (r.startRequest) begin
                n.req.op = OP_START;
                n.req.tgl = ~r.req.tgl;
                n.st = S_START;
            end else if (r.stopPending) begin
                n.req.op = OP_STOP;
                n.req.tgl = ~r.req.tgl;
                n.st = S_STOP;
            end else if (fValid) begin
                pop = 1'b1;
                n.req.op = OP_BYTE;
                n.req.data = fData;
                n.req.tgl = ~r.req.tgl;
                n.st = S_BYTE;
            end
            S_BYTE: if (ev.done) begin
                n.st = S_HOLD;
            end
            S_STOP: if (ev.done) begin
                n.stopPending = 1'b0;
                n.st = S_IDLE;
            end
            default: n.st = S_IDLE;
        endcase
        if (startReq) begin
            n.startRequest = 1'b1;
        end
        if (stopReq) begin
            n.stopPending = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    imc_fifo #(.W(FIFO_W), .D(FIFO_D)) uFifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .flush    (flush),
        .inData   (txData),
        .inValid  (txValid),
        .inReady  (fInReady),
        .outData  (fData),
        .outValid (fValid),
        .outReady (pop)
    );

    imc_link uLink (
        .linkClk (linkClk),
        .reset_n (reset_n),
        .pinsIn  (pinsIn),
        .req     (r.req),
        .pinsOut (pinsOut),
        .pinsOe  (pinsOe),
        .busy    (busyL),
        .nack    (nackL),
        .evt     (evtL)
    );

    assign txReady      = fInReady;
    assign startRequest = r.startRequest;
    assign busBusy      = r.b2;
    assign startSeen    = r.startSeen;
    assign stopSeen     = r.stopSeen;
    assign noAck        = r.noAck;
    assign txReadyFlag  = r.txRdy;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_start_defer: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == S_GAP && n.st == S_START) |-> !r.b2)
        else $error("start issued while bus busy");
    chk_tbuf_gap: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == S_GAP && r.cnt != '0) |=> r.st != S_START)
        else $error("start issued before bus free time");
    chk_wait_enter: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == S_IDLE && r.startRequest && r.b2) |=> r.st == S_WAIT)
        else $error("busy bus did not enter idle wait");
    chk_req_clear: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == S_START && ev.done && !startReq)
        |=> !r.startRequest && r.st == S_HOLD)
        else $error("start request not cleared after start");
    chk_wait_flag: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == S_WAIT && mmTx && ev.fall) |=> r.txRdy)
        else $error("ready flag ignored clock in wait");
    chk_wait_loss: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == S_WAIT && mmTx) |=> !fValid)
        else $error("data kept during idle wait");
    chk_flag_guard: assert property (
        @(posedge clk) disable iff (!reset_n)
        (gieWin && ev.stp && r.startSeen && !clrStartSeen)
        |=> r.startSeen)
        else $error("flag cleared inside enable window");
endmodule // imc_start_ctrl

// ==== tb/imc_bus_partner.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Other master on the shared bus
// ----------------------------------------------------------------
module imc_bus_partner (
    input  wire logic  scl,
    input  wire logic  sda,
    output logic       sclOe,
    output logic       sdaOe,
    output logic [7:0] rxByte,
    output int         rxBits
);
    // Clock half period keeps the rate under 50kHz
    localparam int HALF_NS = 12000;

    initial begin
        sclOe  = 1'b0;
        sdaOe  = 1'b0;
        rxByte = 8'h00;
        rxBits = 0;
    end

    // Shift in every bit seen on the bus
    always @(posedge scl) begin
        rxByte <= {rxByte[6:0], sda};
        rxBits <= rxBits + 1;
    end

    task automatic doStart();
        sdaOe = 1'b1;
        #HALF_NS;
        sclOe = 1'b1;
        #HALF_NS;
    endtask

    task automatic doClk(input int cnt);
        repeat (cnt) begin
            #HALF_NS;
            sclOe = 1'b0;
            #HALF_NS;
            sclOe = 1'b1;
        end
    endtask

    task automatic doStop();
        #HALF_NS;
        sclOe = 1'b0;
        #HALF_NS;
        sdaOe = 1'b0;
    endtask
endmodule // imc_bus_partner

// ==== tb/imc_start_ctrl_bench.sv ====
`timescale 1ns/1ps

module imc_start_ctrl_bench;
    import imc_pkg::*;
    logic         clk = 1'b0;
    logic         linkClk = 1'b0;
    logic         reset_n, startReq, stopReq, multiMasterEnable;
    logic         transmitterSelect, fastMode, clrNoAck, txValid;
    logic         globalIrqEnable, clrStartSeen, clrStopSeen;
    logic [7:0]   txData, rxByte;
    logic         txReady, startRequest, busBusy, startSeen;
    logic         stopSeen, noAck, txReadyFlag, sclOeP, sdaOeP;
    imc_pins_type pinsOe, pinsOut;
    int           fails = 0;
    int           checked = 0;
    int           rxBits, n;
    int           rxBase = 0;
    wire imc_pins_type pinsIn = {~(pinsOe.scl | sclOeP),
                                 ~(pinsOe.sda | sdaOeP)};

    always #12.5 clk = ~clk;
    always #7.5 linkClk = ~linkClk;

    imc_start_ctrl uut (.clk(clk), .reset_n(reset_n), .linkClk(linkClk),
        .startReq(startReq), .stopReq(stopReq),
        .multiMasterEnable(multiMasterEnable),
        .transmitterSelect(transmitterSelect), .fastMode(fastMode),
        .globalIrqEnable(globalIrqEnable), .clrStartSeen(clrStartSeen),
        .clrStopSeen(clrStopSeen),
        .clrNoAck(clrNoAck), .txData(txData), .txValid(txValid),
        .txReady(txReady), .pinsIn(pinsIn), .pinsOut(pinsOut),
        .pinsOe(pinsOe),
        .startRequest(startRequest), .busBusy(busBusy),
        .startSeen(startSeen), .stopSeen(stopSeen), .noAck(noAck),
        .txReadyFlag(txReadyFlag));

    imc_bus_partner bp (.scl(pinsIn.scl), .sda(pinsIn.sda),
        .sclOe(sclOeP), .sdaOe(sdaOeP), .rxByte(rxByte), .rxBits(rxBits));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        if (fails == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic sigOf(input int sel);
        case (sel)
            0: return busBusy;
            1: return startRequest;
            2: return pinsOe.sda;
            3: return txReadyFlag;
            4: return logic'(rxBits == rxBase + 8);
            6: return logic'(busBusy === 1'b1 && uut.r.b1 === 1'b0);
            default: return noAck;
        endcase
    endfunction

    task automatic waitSig(input int sel, input logic want, input int lim,
                           output int cnt);
        cnt = 0;
        while (sigOf(sel) !== want && cnt < lim) begin
            @(posedge clk);
            cnt++;
        end
        if (cnt >= lim) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time,
                     sigOf(sel), want);
            end_sim();
        end
    endtask

    task automatic sendByte(input logic [7:0] b);
        int k;
        k = 0;
        @(posedge clk);
        txData  <= b;
        txValid <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (txReady !== 1'b1 && k < 50);
        txValid <= 1'b0;
        chk(16'(k < 50), 16'h0001);
        if (k >= 50) begin
            end_sim();
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic scnReset();
        chk({startRequest, busBusy, startSeen, stopSeen, noAck, pinsOut},
            16'h0000);
    endtask

    task automatic scnFastStart();
        fastMode <= 1'b1;
        chk(busBusy, 16'h0000);
        @(posedge clk) startReq <= 1'b1;
        @(posedge clk) startReq <= 1'b0;
        waitSig(2, 1'b1, 400, n);
        chk(16'(n >= int'(TBUF_FAST_CYC) && n < int'(TBUF_STD_CYC)),
            16'h0001);
        waitSig(1, 1'b0, 1000, n);
        chk({startSeen, busBusy}, 16'h0003);
        @(posedge clk) stopReq <= 1'b1;
        @(posedge clk) stopReq <= 1'b0;
        waitSig(6, 1'b1, 3000, n);
        globalIrqEnable <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        chk({stopSeen, startSeen, busBusy}, 16'h0006);
        @(posedge clk) {clrStartSeen, clrStopSeen} <= 2'b11;
        @(posedge clk) {clrStartSeen, clrStopSeen} <= 2'b00;
        @(posedge clk);
        chk({stopSeen, startSeen}, 16'h0000);
    endtask

    task automatic scnWaitLoss();
        fastMode          <= 1'b0;
        multiMasterEnable <= 1'b1;
        transmitterSelect <= 1'b1;
        bp.doStart();
        waitSig(0, 1'b1, 20, n);
        @(posedge clk) startReq <= 1'b1;
        @(posedge clk) startReq <= 1'b0;
        sendByte(8'h3C);
        @(posedge clk);
        chk({startRequest, pinsOe.sda, txReadyFlag},
            16'h0004);
        bp.doClk(2);
        waitSig(3, 1'b1, 50, n);
        bp.doStop();
        waitSig(0, 1'b0, 20, n);
        @(posedge clk);
        chk(startSeen, 16'h0000);
        waitSig(2, 1'b1, 1000, n);
        chk(16'(n >= int'(TBUF_STD_CYC)), 16'h0001);
        waitSig(1, 1'b0, 1000, n);
        rxBase = rxBits;
        sendByte(8'hA5);
        waitSig(4, 1'b1, 20000, n);
        chk(rxByte, 16'h00A5);
        waitSig(5, 1'b1, 3000, n);
        @(posedge clk) startReq <= 1'b1;
        @(posedge clk) startReq <= 1'b0;
        waitSig(1, 1'b1, 5, n);
        waitSig(1, 1'b0, 3000, n);
        chk({noAck, busBusy, stopSeen}, 16'h0002);
        sendByte(8'h5A);
        waitSig(5, 1'b1, 20000, n);
        @(posedge clk) clrNoAck <= 1'b1;
        @(posedge clk) clrNoAck <= 1'b0;
        @(posedge clk);
        chk(noAck, 16'h0000);
        @(posedge clk) stopReq <= 1'b1;
        @(posedge clk) stopReq <= 1'b0;
        waitSig(0, 1'b0, 6000, n);
    endtask

    initial begin
        reset_n           = 1'b0;
        startReq          = 1'b0;
        stopReq           = 1'b0;
        multiMasterEnable = 1'b0;
        transmitterSelect = 1'b0;
        fastMode          = 1'b0;
        clrNoAck          = 1'b0;
        globalIrqEnable   = 1'b0;
        clrStartSeen      = 1'b0;
        clrStopSeen       = 1'b0;
        txValid           = 1'b0;
        txData            = 8'h00;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        scnReset();
        scnFastStart();
        scnWaitLoss();
        end_sim();
    end
endmodule // imc_start_ctrl_bench
